// [src/fod_decode_exec.sv]
// Float operate group decoder and executor with its own register file.
// Assumes the integer unit issues one word per cycle, synchronous to sys_clk.
module fod_decode_exec #(
    parameter int NREG = 32                    // Float register count
) (
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic        issue_valid,      // Word offered this cycle
    input  wire logic [31:0] issue_word,       // Instruction word
    input  wire logic        fpu_enable,       // Float unit switched on
    input  wire logic [1:0]  round_dir,        // Rounding direction
    input  wire logic [4:0]  trap_mask,        // Exceptions that trap
    input  wire logic        load_valid,       // Register preload strobe
    input  wire logic [4:0]  load_addr,        // Preload register
    input  wire logic [31:0] load_data,        // Preload value
    input  wire logic [4:0]  peek_addr,        // Readback register
    output logic             done_q,           // Operation completed
    output logic             float_unit_off_trap_q,
    output logic             float_arith_trap_q,
    output logic             unimplemented_float_op_trap_q,
    output logic             pending_q,        // Exception awaiting trap
    output logic [4:0]       cexc_q,           // Flags of last operation
    output logic [31:0]      peek_data_q       // Readback value
);
    if (NREG != 32) begin : g_chk
        $error("NREG must be 32 to match the 5-bit register fields");
    end

    logic [31:0]   regs_q [NREG];              // Float registers
    fod_pkg::fod_op_e opc;                     // Decoded class
    logic [4:0]    rd_f, rs1_f, rs2_f;         // Register fields
    logic [31:0]   s1, s1n, s2, s2n;           // Source words
    logic          run;                        // Executes this cycle
    logic          we0, we1;                   // Destination writes
    logic [31:0]   wd0, wd1;                   // Destination data
    logic [4:0]    exc;                        // Raised flags
    logic [31:0]   mag, nrm;                   // Integer magnitude
    logic [4:0]    lz;                         // Leading zeros
    logic [8:0]    ie;                         // Integer exponent
    logic [31:0]   itos_r;                     // Rounded single
    logic          i_inc;                      // Single rounding up
    logic          md;                         // Double multiply
    logic [63:0]   ma, mb;                     // Multiply operands
    logic [10:0]   ea, eb, bias, emax;         // Exponent fields
    logic [52:0]   fa, fb;                     // Significands
    logic [105:0]  prod, p;                    // Raw and aligned product
    logic signed [13:0] er;                    // Result exponent
    logic          ms, m_inc, lsb, gb, st;     // Sign and round bits
    logic [62:0]   mr;                         // Rounded magnitude
    logic [63:0]   mres;                       // Multiply result

    // Field extraction
    assign opc   = fod_pkg::fod_classify(issue_word);
    assign rd_f  = issue_word[fod_pkg::RD_LSB +: 5];
    assign rs1_f = issue_word[fod_pkg::RS1_LSB +: 5];
    assign rs2_f = issue_word[fod_pkg::RS2_LSB +: 5];
    assign s1    = regs_q[rs1_f];
    assign s1n   = regs_q[5'(rs1_f + 5'h01)];
    assign s2    = regs_q[rs2_f];
    assign s2n   = regs_q[5'(rs2_f + 5'h01)];
    // Execute only when on, nothing pending, and code is implemented
    assign run = issue_valid && fpu_enable && !pending_q &&
                 opc != fod_pkg::OPC_NONE && opc != fod_pkg::OPC_QUAD && opc != fod_pkg::OPC_BAD;

    // Round-up decision for a given direction
    function automatic logic rnd_up(input logic [1:0] rd, input logic s, input logic l,
                                    input logic g, input logic t);
        case (rd)
            fod_pkg::RND_NEAR: return g && (t || l);
            fod_pkg::RND_ZERO: return 1'b0;
            fod_pkg::RND_POS:  return !s && (g || t);
            default:           return s && (g || t);
        endcase
    endfunction

    // Integer conversion datapath
    always_comb begin
        mag = s2[31] ? 32'(-s2) : s2;
        lz  = 5'h00;
        for (int i = 0; i < 32; i++) begin
            if (mag[i]) begin
                lz = 5'(31 - i);
            end
        end
        nrm    = mag << lz;
        ie     = 9'(8'd31 - 8'(lz));
        i_inc  = rnd_up(round_dir, s2[31], nrm[8], nrm[7], |nrm[6:0]);
        itos_r = {s2[31], 31'({8'(ie + 9'h07f), nrm[30:8]} + 31'(i_inc))};
    end

    // Multiply datapath, normal operands; subnormals count as zero
    always_comb begin
        md   = (opc == fod_pkg::OPC_MULD);
        ma   = md ? {s1, s1n} : {s1, 32'h0000_0000};
        mb   = md ? {s2, s2n} : {s2, 32'h0000_0000};
        bias = md ? fod_pkg::BIAS_D : fod_pkg::BIAS_S;
        emax = md ? fod_pkg::EMAX_D : fod_pkg::EMAX_S;
        ea   = md ? ma[62:52] : 11'(ma[62:55]);
        eb   = md ? mb[62:52] : 11'(mb[62:55]);
        fa   = md ? {1'b1, ma[51:0]} : {1'b1, ma[54:32], 29'h0};
        fb   = md ? {1'b1, mb[51:0]} : {1'b1, mb[54:32], 29'h0};
        ms   = ma[63] ^ mb[63];
        prod = fa * fb;
        p    = prod[105] ? prod : prod << 1;
        er   = 14'(ea) + 14'(eb) - 14'(bias) + 14'(prod[105]);
        lsb  = md ? p[53] : p[82];
        gb   = md ? p[52] : p[81];
        st   = md ? |p[51:0] : |p[80:0];
        m_inc = rnd_up(round_dir, ms, lsb, gb, st);
        mr   = md ? 63'({er[10:0], p[104:53]} + 63'(m_inc))
                  : {31'(({er[7:0], p[104:82]}) + 31'(m_inc)), 32'h0000_0000};
        exc  = 5'h00;
        mres = {ms, mr};
        if (ea == emax || eb == emax) begin
            // Infinity or NaN operand; inf times zero is invalid
            if ((ea == emax && (md ? |ma[51:0] : |ma[54:32])) ||
                (eb == emax && (md ? |mb[51:0] : |mb[54:32])) || ea == 11'h000 || eb == 11'h000) begin
                exc[fod_pkg::EXC_NV] = 1'b1;
                mres = md ? 64'h7ff8_0000_0000_0000 : 64'h7fc0_0000_0000_0000;
            end else begin
                mres = md ? {ms, 63'h7ff0_0000_0000_0000} : {ms, 63'h7f80_0000_0000_0000};
            end
        end else if (ea == 11'h000 || eb == 11'h000) begin
            mres = {ms, 63'h0};
        end else if (er >= signed'(14'(emax))) begin
            exc[fod_pkg::EXC_OF] = 1'b1;
            exc[fod_pkg::EXC_NX] = 1'b1;
            mres = md ? {ms, 63'h7ff0_0000_0000_0000} : {ms, 63'h7f80_0000_0000_0000};
        end else if (er <= 14'sd0) begin
            exc[fod_pkg::EXC_UF] = 1'b1;
            exc[fod_pkg::EXC_NX] = 1'b1;
            mres = {ms, 63'h0};
        end else begin
            exc[fod_pkg::EXC_NX] = gb | st;
            exc[fod_pkg::EXC_OF] = md ? (mr[62:52] == emax) : (mr[62:55] == emax[7:0]);
        end
    end

    // Result select per operation
    always_comb begin
        we0 = 1'b0;
        we1 = 1'b0;
        wd0 = s2;
        wd1 = 32'h0000_0000;
        case (opc)
            fod_pkg::OPC_ITOD: begin
                we0 = 1'b1;
                we1 = 1'b1;
                {wd0, wd1} = (mag == 32'h0000_0000) ? 64'h0 :
                             {s2[31], 11'(11'(ie) + fod_pkg::BIAS_D), nrm[30:0], 21'h0};
            end
            fod_pkg::OPC_ITOS: begin
                we0 = 1'b1;
                wd0 = (mag == 32'h0000_0000) ? 32'h0000_0000 : itos_r;
            end
            fod_pkg::OPC_MOVS: we0 = 1'b1;
            fod_pkg::OPC_NEGS: begin
                we0 = 1'b1;
                wd0 = s2 ^ fod_pkg::SIGN_MASK;
            end
            fod_pkg::OPC_MULD: begin
                we0 = 1'b1;
                we1 = 1'b1;
                {wd0, wd1} = mres;
            end
            fod_pkg::OPC_MULS: begin
                we0 = 1'b1;
                wd0 = mres[63:32];
            end
            default: we0 = 1'b0;
        endcase
    end

    // Register file writes; execution wins over a same-cycle preload
    always_ff @(posedge sys_clk) begin
        if (load_valid) begin
            regs_q[load_addr] <= load_data;
        end
        if (run && we0) begin
            regs_q[rd_f] <= wd0;
        end
        if (run && we1) begin
            regs_q[5'(rd_f + 5'h01)] <= wd1;
        end
    end

    // Completion, traps and flags
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            done_q                        <= 1'b0;
            float_unit_off_trap_q         <= 1'b0;
            float_arith_trap_q            <= 1'b0;
            unimplemented_float_op_trap_q <= 1'b0;
            cexc_q                        <= 5'h00;
            pending_q                     <= 1'b0;
        end else begin
            done_q <= run;
            float_unit_off_trap_q <= issue_valid && !fpu_enable && opc != fod_pkg::OPC_NONE;
            float_arith_trap_q <= issue_valid && fpu_enable && pending_q && opc != fod_pkg::OPC_NONE;
            unimplemented_float_op_trap_q <= issue_valid && fpu_enable && !pending_q &&
                (opc == fod_pkg::OPC_QUAD || opc == fod_pkg::OPC_BAD);
            if (run) begin
                // Only multiplies and the single conversion raise flags
                if (opc == fod_pkg::OPC_MULD || opc == fod_pkg::OPC_MULS) begin
                    cexc_q    <= exc;
                    pending_q <= |(exc & trap_mask);
                end else if (opc == fod_pkg::OPC_ITOS) begin
                    cexc_q    <= {4'h0, mag != 32'h0000_0000 && |nrm[7:0]};
                    pending_q <= trap_mask[fod_pkg::EXC_NX] && mag != 32'h0000_0000 && |nrm[7:0];
                end else begin
                    cexc_q <= 5'h00;
                end
            end else if (float_arith_trap_q) begin
                pending_q <= 1'b0;
            end
        end
    end

    // Readback
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            peek_data_q <= fod_pkg::RESET_WORD;
        end else begin
            peek_data_q <= regs_q[peek_addr];
        end
    end

    property p_dec;
        @(posedge sys_clk) disable iff (!resetn)
        issue_valid && issue_word[31:30] != 2'h2 |=> !done_q && !unimplemented_float_op_trap_q;
    endproperty
    a_dec: assert property (p_dec) else $error("foreign word acted on");
    property p_quad;
        @(posedge sys_clk) disable iff (!resetn)
        run == 1'b0 && opc == fod_pkg::OPC_QUAD && fpu_enable && !pending_q && issue_valid
        |=> unimplemented_float_op_trap_q && !done_q;
    endproperty
    a_quad: assert property (p_quad) else $error("quad form not trapped");
    property p_bad;
        @(posedge sys_clk) disable iff (!resetn)
        issue_valid && opc == fod_pkg::OPC_BAD && fpu_enable && !pending_q |=> unimplemented_float_op_trap_q;
    endproperty
    a_bad: assert property (p_bad) else $error("unlisted code not trapped");
    property p_mov;
        @(posedge sys_clk) disable iff (!resetn)
        run && opc == fod_pkg::OPC_MOVS && !load_valid |=> regs_q[$past(rd_f)] == $past(s2);
    endproperty
    a_mov: assert property (p_mov) else $error("move altered word");
    property p_neg;
        @(posedge sys_clk) disable iff (!resetn)
        run && opc == fod_pkg::OPC_NEGS |=> regs_q[$past(rd_f)] == ($past(s2) ^ 32'h8000_0000) && cexc_q == 5'h00;
    endproperty
    a_neg: assert property (p_neg) else $error("negate wrong");
    property p_itos;
        @(posedge sys_clk) disable iff (!resetn)
        run && opc == fod_pkg::OPC_ITOS |=> cexc_q[4:1] == 4'h0;
    endproperty
    a_itos: assert property (p_itos) else $error("single conversion raised non-inexact");
    property p_itod0;
        @(posedge sys_clk) disable iff (!resetn)
        run && opc == fod_pkg::OPC_ITOD && s2 == 32'h0000_0001 && rd_f == 5'h02
        |=> regs_q[2] == 32'h3ff0_0000 && regs_q[3] == 32'h0000_0000;
    endproperty
    a_itod0: assert property (p_itod0) else $error("integer one to double wrong");
    property p_mul;
        @(posedge sys_clk) disable iff (!resetn)
        run && (opc == fod_pkg::OPC_MULD || opc == fod_pkg::OPC_MULS) |=> !cexc_q[fod_pkg::EXC_DZ] && done_q;
    endproperty
    a_mul: assert property (p_mul) else $error("multiply flagged divide");
    property p_pend;
        @(posedge sys_clk) disable iff (!resetn)
        issue_valid && fpu_enable && pending_q && opc != fod_pkg::OPC_NONE
        |=> float_arith_trap_q && !done_q ##1 !pending_q;
    endproperty
    a_pend: assert property (p_pend) else $error("pending exception not trapped");
    property p_off;
        @(posedge sys_clk) disable iff (!resetn)
        issue_valid && !fpu_enable && opc != fod_pkg::OPC_NONE |=> float_unit_off_trap_q && !done_q;
    endproperty
    a_off: assert property (p_off) else $error("disabled unit executed");
endmodule

// [src/fod_pkg.sv]
// Constants, opcodes and decode helper for the float operate decode/execute block.
// Assumes a 32-bit instruction word and 32 single-word float registers.
package fod_pkg;
    // Instruction field positions
    localparam int OP_MSB   = 31;             // Top format bits
    localparam int RD_LSB   = 25;             // Destination field
    localparam int OP3_LSB  = 19;             // Group select field
    localparam int RS1_LSB  = 14;             // First source field
    localparam int OPF_LSB  = 5;              // Operation code field
    localparam int RS2_LSB  = 0;              // Second source field
    localparam logic [1:0] OP_FMT    = 2'h2;  // Format binary 10
    localparam logic [5:0] OP3_FPOP  = 6'h34; // Group binary 110100
    // Operation codes of this group
    localparam logic [8:0] OPF_ITOD  = 9'h0c8;
    localparam logic [8:0] OPF_ITOS  = 9'h0c4;
    localparam logic [8:0] OPF_ITOQ  = 9'h0cc;
    localparam logic [8:0] OPF_MULQ  = 9'h04b;
    localparam logic [8:0] OPF_QTOD  = 9'h0cb;
    localparam logic [8:0] OPF_MOVS  = 9'h001;
    localparam logic [8:0] OPF_NEGS  = 9'h005;
    localparam logic [8:0] OPF_MULD  = 9'h04a;
    localparam logic [8:0] OPF_MULS  = 9'h049;
    // Exception flag positions
    localparam int EXC_NV = 4;
    localparam int EXC_OF = 3;
    localparam int EXC_UF = 2;
    localparam int EXC_DZ = 1;
    localparam int EXC_NX = 0;
    // Rounding directions
    localparam logic [1:0] RND_NEAR = 2'h0;
    localparam logic [1:0] RND_ZERO = 2'h1;
    localparam logic [1:0] RND_POS  = 2'h2;
    localparam logic [1:0] RND_NEG  = 2'h3;
    // Formats
    localparam logic [31:0] SIGN_MASK = 32'h8000_0000;
    localparam logic [10:0] BIAS_D    = 11'h3ff;
    localparam logic [10:0] BIAS_S    = 11'h07f;
    localparam logic [10:0] EMAX_D    = 11'h7ff;
    localparam logic [10:0] EMAX_S    = 11'h0ff;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    typedef enum {OPC_ITOD, OPC_ITOS, OPC_MOVS, OPC_NEGS,
                  OPC_MULD, OPC_MULS, OPC_QUAD, OPC_BAD, OPC_NONE} fod_op_e;

    // Classify a word; OPC_NONE when it is outside this group
    function automatic fod_op_e fod_classify(input logic [31:0] w);
        if (w[OP_MSB -: 2] != OP_FMT || w[OP3_LSB +: 6] != OP3_FPOP) begin
            return OPC_NONE;
        end
        case (w[OPF_LSB +: 9])
            OPF_ITOD: return OPC_ITOD;
            OPF_ITOS: return OPC_ITOS;
            OPF_MOVS: return OPC_MOVS;
            OPF_NEGS: return OPC_NEGS;
            OPF_MULD: return OPC_MULD;
            OPF_MULS: return OPC_MULS;
            OPF_ITOQ, OPF_MULQ, OPF_QTOD: return OPC_QUAD;
            default: return OPC_BAD;
        endcase
    endfunction
endpackage

// [verification/fod_int_unit_model.sv]
// Integer-unit side: issues float operate words and collects the block's answers.
// Assumes sys_clk is shared with the block; a call starts just after a falling edge.
module fod_int_unit_model (
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    output logic             issue_valid,
    output logic [31:0]      issue_word,
    input  wire logic        done_q,
    input  wire logic        float_unit_off_trap_q,
    input  wire logic        float_arith_trap_q,
    input  wire logic        unimplemented_float_op_trap_q
);
    timeunit 1ns;
    timeprecision 100ps;
    int   traps_taken;   // Float exception traps taken so far
    logic up;            // Valid left raised by a chained call
    // Idle lines at time zero
    initial begin
        issue_valid = 1'b0;
        issue_word  = 32'h0000_0000;
        traps_taken = 0;
        up          = 1'b0;
    end
    // Offer one word; answer comes back as {off, arith, unimp, done}
    task automatic issue(input logic [31:0] w, input logic keep, output logic [3:0] resp);
        if (!up) @(negedge sys_clk);
        issue_valid = 1'b1;
        issue_word  = w;
        @(negedge sys_clk);
        resp = {float_unit_off_trap_q, float_arith_trap_q, unimplemented_float_op_trap_q, done_q};
        if (float_arith_trap_q === 1'b1) traps_taken++;
        up = keep;
        // Released lines show the inverse, not a stale word
        if (!keep) begin
            issue_valid = 1'b0;
            issue_word  = ~w;
        end
    endtask
endmodule

// [verification/test_fod_decode_exec.sv]
// Self-checking bench for the float operate decode/execute block.
// Assumes the integer-unit model drives issue lines; the bench drives the rest at falling edges.
module test_fod_decode_exec;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [3:0] R_NONE = 4'h0, R_DONE = 4'h1, R_UNIMP = 4'h2, R_ARITH = 4'h4, R_OFF = 4'h8;
    logic        sys_clk, resetn, issue_valid, fpu_enable, load_valid;
    logic [31:0] issue_word, load_data, peek_data_q;
    logic [1:0]  round_dir;
    logic [4:0]  trap_mask, load_addr, peek_addr, cexc_q;
    logic        done_q, off_q, arith_q, unimp_q, pending_q;
    int          n_errors, tests_run;
    // Device under test
    fod_decode_exec fod_decode_exec_i (.sys_clk(sys_clk), .resetn(resetn), .issue_valid(issue_valid),
        .issue_word(issue_word), .fpu_enable(fpu_enable), .round_dir(round_dir), .trap_mask(trap_mask),
        .load_valid(load_valid), .load_addr(load_addr), .load_data(load_data), .peek_addr(peek_addr),
        .done_q(done_q), .float_unit_off_trap_q(off_q), .float_arith_trap_q(arith_q),
        .unimplemented_float_op_trap_q(unimp_q), .pending_q(pending_q), .cexc_q(cexc_q),
        .peek_data_q(peek_data_q));
    // Issuing side
    fod_int_unit_model fod_int_unit_model_i (.sys_clk(sys_clk), .resetn(resetn), .issue_valid(issue_valid),
        .issue_word(issue_word), .done_q(done_q), .float_unit_off_trap_q(off_q),
        .float_arith_trap_q(arith_q), .unimplemented_float_op_trap_q(unimp_q));
    // 250 MHz clock
    initial sys_clk = 1'b0;
    always #2 sys_clk = ~sys_clk;
    // Word compare
    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: expected %h got %h", $time, exp, got);
        end
    endtask
    // Flag and answer compare
    task automatic chkf(input logic [4:0] exp, input logic [4:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: expected %h got %h", $time, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Build a group word from code and register numbers
    function automatic logic [31:0] fw(input logic [8:0] c, input int d, a, b);
        return {fod_pkg::OP_FMT, 5'(d), fod_pkg::OP3_FPOP, 5'(a), c, 5'(b)};
    endfunction
    // Preload one register
    task automatic ld(input int a, input logic [31:0] d);
        @(negedge sys_clk);
        load_valid = 1'b1;
        load_addr  = 5'(a);
        load_data  = d;
        @(negedge sys_clk);
        load_valid = 1'b0;
    endtask
    // Read a register back and compare
    task automatic xreg(input int a, input logic [31:0] exp);
        @(negedge sys_clk);
        peek_addr = 5'(a);
        @(negedge sys_clk);
        chk(exp, peek_data_q);
    endtask
    // Issue, compare the answer, and the flags when executed
    task automatic op(input logic [31:0] w, input logic [3:0] er, input logic [4:0] ef);
        logic [3:0] r;
        fod_int_unit_model_i.issue(w, 1'b0, r);
        chkf({1'b0, er}, {1'b0, r});
        if (er === R_DONE) chkf(ef, cexc_q);
    endtask
    // Move, one word only; words outside the group are ignored
    task automatic t_move();
        ld(5, 32'h1234_5678);
        ld(4, 32'h0bad_0bad);
        op(fw(fod_pkg::OPF_MOVS, 3, 5'h1f, 5), R_DONE, 5'h00);
        xreg(3, 32'h1234_5678);
        xreg(4, 32'h0bad_0bad);
        op(fw(fod_pkg::OPF_MOVS, 3, 0, 4) ^ 32'h4000_0000, R_NONE, 5'h00);
        op(fw(fod_pkg::OPF_MOVS, 3, 0, 4) ^ 32'h0008_0000, R_NONE, 5'h00);
        xreg(3, 32'h1234_5678);
    endtask
    // Negate on odd and even registers, a signalling NaN, and back to back
    task automatic t_neg();
        logic [3:0] r;
        ld(9, 32'h3f80_0000);
        ld(11, 32'h7f80_0001);
        op(fw(fod_pkg::OPF_NEGS, 7, 0, 9), R_DONE, 5'h00);
        xreg(7, 32'hbf80_0000);
        op(fw(fod_pkg::OPF_NEGS, 10, 0, 11), R_DONE, 5'h00);
        xreg(10, 32'hff80_0001);
        fod_int_unit_model_i.issue(fw(fod_pkg::OPF_MOVS, 14, 0, 9), 1'b1, r);
        chkf({1'b0, R_DONE}, {1'b0, r});
        fod_int_unit_model_i.issue(fw(fod_pkg::OPF_NEGS, 15, 0, 14), 1'b0, r);
        chkf({1'b0, R_DONE}, {1'b0, r});
        xreg(15, 32'hbf80_0000);
    endtask
    // Integer to double, destination pair wraps past the last register
    task automatic t_itod();
        ld(2, 32'hffff_ffff);
        ld(0, 32'h5555_5555);
        op(fw(fod_pkg::OPF_ITOD, 31, 5'h0a, 2), R_DONE, 5'h00);
        xreg(31, 32'hbff0_0000);
        xreg(0, 32'h0000_0000);
        ld(4, 32'h0000_0001);
        op(fw(fod_pkg::OPF_ITOD, 2, 0, 4), R_DONE, 5'h00);
        xreg(2, 32'h3ff0_0000);
        xreg(3, 32'h0000_0000);
    endtask
    // Integer to single: exact case, then a tie under every rounding direction
    task automatic t_itos();
        logic [31:0] tbl [4] = '{32'h4b80_0000, 32'h4b80_0000, 32'h4b80_0001, 32'h4b80_0000};
        ld(6, 32'h0100_0001);
        ld(1, 32'h0000_0003);
        op(fw(fod_pkg::OPF_ITOS, 8, 0, 1), R_DONE, 5'h00);
        xreg(8, 32'h4040_0000);
        for (int k = 0; k < 4; k++) begin
            round_dir = 2'(k);
            op(fw(fod_pkg::OPF_ITOS, 8, 0, 6), R_DONE, 5'h01);
            xreg(8, tbl[k]);
        end
        round_dir = fod_pkg::RND_NEAR;
    endtask
    // Single multiply plain, overflow, invalid and underflow; double multiply plain only
    task automatic t_mul();
        ld(16, 32'h4000_0000);
        ld(17, 32'h4040_0000);
        ld(19, 32'h7f00_0000);
        ld(20, 32'h7f80_0000);
        ld(21, 32'h0000_0000);
        op(fw(fod_pkg::OPF_MULS, 18, 16, 17), R_DONE, 5'h00);
        xreg(18, 32'h40c0_0000);
        op(fw(fod_pkg::OPF_MULS, 18, 19, 19), R_DONE, 5'h09);
        xreg(18, 32'h7f80_0000);
        op(fw(fod_pkg::OPF_MULS, 18, 20, 21), R_DONE, 5'h10);
        xreg(18, 32'h7fc0_0000);
        ld(29, 32'h0080_0000);
        op(fw(fod_pkg::OPF_MULS, 18, 29, 29), R_DONE, 5'h05);
        xreg(18, 32'h0000_0000);
        ld(22, 32'h4000_0000);
        ld(23, 32'h0000_0000);
        ld(24, 32'h3ff8_0000);
        ld(25, 32'h0000_0000);
        ld(27, 32'hffff_ffff);
        op(fw(fod_pkg::OPF_MULD, 26, 22, 24), R_DONE, 5'h00);
        xreg(26, 32'h4008_0000);
        xreg(27, 32'h0000_0000);
    endtask
    // Quad forms and unlisted codes trap, write nothing
    task automatic t_unimp();
        logic [8:0] q [3] = '{fod_pkg::OPF_ITOQ, fod_pkg::OPF_MULQ, fod_pkg::OPF_QTOD};
        logic [8:0] u [3] = '{9'h04d, 9'h1ff, 9'h000};
        ld(12, 32'h1357_9bdf);
        foreach (q[i]) op(fw(q[i], 12, 16, 17), R_UNIMP, 5'h00);
        foreach (u[i]) op(fw(u[i], 12, 16, 17), R_UNIMP, 5'h00);
        xreg(12, 32'h1357_9bdf);
    endtask
    // Unit switched off
    task automatic t_off();
        fpu_enable = 1'b0;
        op(fw(fod_pkg::OPF_MOVS, 12, 0, 5), R_OFF, 5'h00);
        op(fw(fod_pkg::OPF_ITOQ, 12, 0, 5), R_OFF, 5'h00);
        op(fw(fod_pkg::OPF_MOVS, 12, 0, 5) ^ 32'h4000_0000, R_NONE, 5'h00);
        xreg(12, 32'h1357_9bdf);
        fpu_enable = 1'b1;
    endtask
    // Trapping overflow leaves an exception that the next word takes
    task automatic t_pending();
        trap_mask = 5'h08;
        ld(28, 32'h2468_ace0);
        op(fw(fod_pkg::OPF_MULS, 18, 19, 19), R_DONE, 5'h09);
        chkf(5'h01, {4'h0, pending_q});
        op(fw(fod_pkg::OPF_MOVS, 28, 0, 5), R_ARITH, 5'h00);
        xreg(28, 32'h2468_ace0);
        chkf(5'h00, {4'h0, pending_q});
        chk(32'h0000_0001, 32'(fod_int_unit_model_i.traps_taken));
        trap_mask = 5'h00;
    endtask
    // Hang guard
    initial begin
        #40000;
        n_errors++;
        give_verdict();
    end
    // Main sequence
    initial begin
        n_errors   = 0;
        tests_run  = 0;
        resetn     = 1'b0;
        fpu_enable = 1'b1;
        round_dir  = fod_pkg::RND_NEAR;
        trap_mask  = 5'h00;
        load_valid = 1'b0;
        load_addr  = 5'h00;
        load_data  = 32'h0000_0000;
        peek_addr  = 5'h00;
        repeat (2) @(negedge sys_clk);
        chkf(5'h00, {done_q, off_q, arith_q, unimp_q, pending_q});
        chkf(5'h00, cexc_q);
        @(negedge sys_clk);
        resetn = 1'b1;
        t_move();
        t_neg();
        t_itod();
        t_itos();
        t_mul();
        t_unimp();
        t_off();
        t_pending();
        give_verdict();
    end
endmodule
